// File: logic/brs_top.sv
// Bridge secondary-side configuration bank with I/O window decode
`timescale 1ns/1ns
`include "brs_regs.svh"

module brs_top (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire brs_pkg::brs_bus_req_t bus_req,
   output logic [31:0] rdata,
   input wire brs_pkg::brs_flags_t events,
   input wire logic [15:0] io_base_upper,
   input wire logic [15:0] io_limit_upper,
   input wire brs_pkg::brs_io_req_t io_req,
   output logic io_fwd_valid,
   output logic io_fwd_hit,
   output logic [1:0] ctrl,
   output logic irq
);

   // ****************************************************************
   // State
   // ****************************************************************
   brs_pkg::brs_state_t st;
   brs_pkg::brs_state_t next_st;

   logic [31:0] win_base;
   logic [31:0] win_limit;
   logic [31:0] word_bus;
   logic [31:0] word_io;
   brs_pkg::brs_flags_t gated_ev;
   brs_pkg::brs_flags_t w1c;
   brs_pkg::brs_flags_t irq_rd_clr;
   logic wr_bus;
   logic wr_io;
   logic wr_ctrl;
   logic wr_mask;
   wire logic [`BRS_FLAGS_HI:0] next_sec_bits;
   wire logic [`BRS_FLAGS_HI:0] next_irq_bits;

   // ****************************************************************
   // Window and read words
   // ****************************************************************
   // Upper halves belong to separate registers outside this bank
   assign win_base = {io_base_upper, st.io_base, `BRS_IO_LOW_BASE};
   assign win_limit = {io_limit_upper, st.io_limit, `BRS_IO_LOW_LIM};

   always_comb begin
      word_bus = `BRS_RST_WORD;
      // Latency timer and bus numbers held elsewhere read zero
      word_bus[`BRS_SUB_BUS_HI:`BRS_SUB_BUS_LO] = st.sub_bus;
      word_io = `BRS_RST_WORD;
      word_io[`BRS_IO_IND_BASE_HI:`BRS_IO_IND_BASE_LO] = `BRS_IO_IND_32;
      word_io[`BRS_IO_BASE_HI:`BRS_IO_BASE_LO] = st.io_base;
      word_io[`BRS_IO_IND_LIM_HI:`BRS_IO_IND_LIM_LO] = `BRS_IO_IND_32;
      word_io[`BRS_IO_LIM_HI:`BRS_IO_LIM_LO] = st.io_limit;
      word_io[`BRS_ST_PAR] = st.sec_stat.par;
      word_io[`BRS_ST_SIG_CA] = st.sec_stat.sig_ca;
      word_io[`BRS_ST_RCV_CA] = st.sec_stat.rcv_ca;
      word_io[`BRS_ST_RCV_UR] = st.sec_stat.rcv_ur;
      word_io[`BRS_ST_SERR] = st.sec_stat.serr;
      word_io[`BRS_ST_POISON] = st.sec_stat.poison;
   end

   // ****************************************************************
   // Event gating and write decode
   // ****************************************************************
   always_comb begin
      gated_ev = events;
      gated_ev.par = events.par & st.ctrl[`BRS_CTRL_PERR_EN];
      gated_ev.serr = events.serr & st.ctrl[`BRS_CTRL_SERR_EN];
   end

   assign wr_bus = bus_req.wr && (bus_req.addr == `BRS_OFS_BUS);
   assign wr_io = bus_req.wr && (bus_req.addr == `BRS_OFS_IO_STAT);
   assign wr_ctrl = bus_req.wr && (bus_req.addr == `BRS_OFS_CTRL);
   assign wr_mask = bus_req.wr && (bus_req.addr == `BRS_OFS_IRQ_MASK);

   // Bits 27..29 are read-only: software cannot clear them, only reset does
   always_comb begin
      w1c = `BRS_RST_FLAGS;
      if (wr_io) begin
         w1c.par = bus_req.wdata[`BRS_ST_PAR];
         w1c.serr = bus_req.wdata[`BRS_ST_SERR];
         w1c.poison = bus_req.wdata[`BRS_ST_POISON];
      end
   end

   always_comb begin
      irq_rd_clr = `BRS_RST_FLAGS;
      if (bus_req.rd && (bus_req.addr == `BRS_OFS_IRQ_STAT)) begin
         irq_rd_clr = '1;
      end
   end

   // ****************************************************************
   // Sticky flags, one slice per event
   // ****************************************************************
   // A new event wins over a clear in the same cycle, so no event is lost
   generate
      for (genvar i = 0; i < `BRS_NUM_FLAGS; i++) begin : g_flag
         assign next_sec_bits[i] = (st.sec_stat[i] & ~w1c[i]) | gated_ev[i];
         assign next_irq_bits[i] = (st.irq_stat[i] & ~irq_rd_clr[i]) | gated_ev[i];
      end
   endgenerate

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_st = st;
      if (wr_bus) begin
         next_st.sub_bus = bus_req.wdata[`BRS_SUB_BUS_HI:`BRS_SUB_BUS_LO];
      end
      if (wr_io) begin
         next_st.io_base = bus_req.wdata[`BRS_IO_BASE_HI:`BRS_IO_BASE_LO];
         next_st.io_limit = bus_req.wdata[`BRS_IO_LIM_HI:`BRS_IO_LIM_LO];
      end
      if (wr_ctrl) begin
         next_st.ctrl = bus_req.wdata[`BRS_CTRL_SERR_EN:`BRS_CTRL_PERR_EN];
      end
      if (wr_mask) begin
         next_st.irq_mask = bus_req.wdata[`BRS_FLAGS_HI:0];
      end
      next_st.sec_stat = next_sec_bits;
      next_st.irq_stat = next_irq_bits;
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
      next_st.rdata = `BRS_RST_WORD;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            `BRS_OFS_BUS: next_st.rdata = word_bus;
            `BRS_OFS_IO_STAT: next_st.rdata = word_io;
            `BRS_OFS_CTRL: begin
               next_st.rdata[`BRS_CTRL_SERR_EN:`BRS_CTRL_PERR_EN] = st.ctrl;
            end
            `BRS_OFS_IRQ_MASK: begin
               next_st.rdata[`BRS_FLAGS_HI:0] = st.irq_mask;
            end
            `BRS_OFS_IRQ_STAT: begin
               next_st.rdata[`BRS_FLAGS_HI:0] = st.irq_stat;
            end
            // Unmapped offsets read zero
            default: next_st.rdata = `BRS_RST_WORD;
         endcase
      end
      next_st.fwd_valid = io_req.valid;
      next_st.fwd_hit = io_req.valid && (io_req.addr >= win_base)
         && (io_req.addr <= win_limit);
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st.sub_bus <= `BRS_RST_SUB_BUS;
         st.io_base <= `BRS_RST_IO_NIB;
         st.io_limit <= `BRS_RST_IO_NIB;
         st.sec_stat <= `BRS_RST_FLAGS;
         st.ctrl <= `BRS_RST_CTRL;
         st.irq_mask <= `BRS_RST_FLAGS;
         st.irq_stat <= `BRS_RST_FLAGS;
         st.rdata <= `BRS_RST_WORD;
         st.irq <= 1'b0;
         st.fwd_valid <= 1'b0;
         st.fwd_hit <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign io_fwd_valid = st.fwd_valid;
   assign io_fwd_hit = st.fwd_hit;
   assign ctrl = st.ctrl;
   assign irq = st.irq;

endmodule // brs_top

// File: pkg/brs_pkg.sv
// Types shared by the bridge secondary-side register bank
package brs_pkg;

   // Event flags, same layout for status, interrupt status and mask
   typedef struct packed {
      logic poison;
      logic serr;
      logic rcv_ur;
      logic rcv_ca;
      logic sig_ca;
      logic par;
   } brs_flags_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } brs_bus_req_t;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } brs_io_req_t;

   typedef struct packed {
      logic [7:0] sub_bus;
      logic [3:0] io_base;
      logic [3:0] io_limit;
      brs_flags_t sec_stat;
      logic [1:0] ctrl;
      brs_flags_t irq_mask;
      brs_flags_t irq_stat;
      logic [31:0] rdata;
      logic irq;
      logic fwd_valid;
      logic fwd_hit;
   } brs_state_t;

endpackage

// File: pkg/brs_regs.svh
// Register offsets, field positions and reset values of the bridge secondary-side bank
// Functional notes
// - Subordinate bus number: 8-bit read-write field, bits 23:16, reset 00h.
// - Secondary latency timer bits 31:24 read zero; writes ignored.
// - I/O base and limit indicator nibbles read 1h: 32-bit I/O.
// - I/O base bits 7:4 writable, map to address 15:12, low bits zero.
// - I/O limit bits 15:12 writable, map to address 15:12, low bits FFFh.
// - Base and limit bound the I/O range that decides forwarding.
// - Address bits 31:16 of base and limit come from upper-half registers.
// - Status bits 21, 23 and 26:25 read zero; writes ignored.
// - Status bit 24 sets on requester parity error detected or forwarded.
// - Bit 24 never sets while parity error response enable is clear.
// - Status bit 27 sets when completer finishes request with Completer Abort.
// - Status bit 28 sets on received Completion with Completer Abort.
// - Status bit 29 sets on received Completion with Unsupported Request.
// - Status bit 30 sets on sent error message while system-error enable is one.
// - Status bit 31 sets when secondary side receives a poisoned TLP.
`ifndef BRS_REGS_SVH
`define BRS_REGS_SVH

// ****************************************************************
// Offsets
// ****************************************************************
`define BRS_OFS_BUS 8'h18
`define BRS_OFS_IO_STAT 8'h1c
`define BRS_OFS_CTRL 8'h40
`define BRS_OFS_IRQ_MASK 8'h44
`define BRS_OFS_IRQ_STAT 8'h48

// ****************************************************************
// Field positions and values
// ****************************************************************
`define BRS_SUB_BUS_LO 16
`define BRS_SUB_BUS_HI 23
`define BRS_IO_IND_BASE_LO 0
`define BRS_IO_IND_BASE_HI 3
`define BRS_IO_BASE_LO 4
`define BRS_IO_BASE_HI 7
`define BRS_IO_IND_LIM_LO 8
`define BRS_IO_IND_LIM_HI 11
`define BRS_IO_LIM_LO 12
`define BRS_IO_LIM_HI 15
`define BRS_IO_IND_32 4'h1
`define BRS_IO_LOW_BASE 12'h000
`define BRS_IO_LOW_LIM 12'hfff
`define BRS_ST_PAR 24
`define BRS_ST_SIG_CA 27
`define BRS_ST_RCV_CA 28
`define BRS_ST_RCV_UR 29
`define BRS_ST_SERR 30
`define BRS_ST_POISON 31
`define BRS_CTRL_PERR_EN 0
`define BRS_CTRL_SERR_EN 1
`define BRS_NUM_FLAGS 6
`define BRS_FLAGS_HI 5

// ****************************************************************
// Reset values
// ****************************************************************
`define BRS_RST_SUB_BUS 8'h00
`define BRS_RST_IO_NIB 4'h0
`define BRS_RST_FLAGS 6'h00
`define BRS_RST_CTRL 2'h0
`define BRS_RST_WORD 32'h0000_0000

`endif

// File: verif/brs_properties.sv
// Port-level checker for the bridge secondary-side bank
`timescale 1ns/1ns
module brs_properties (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire brs_pkg::brs_bus_req_t bus_req,
   input wire logic [31:0] rdata,
   input wire brs_pkg::brs_flags_t events,
   input wire logic [15:0] io_base_upper,
   input wire logic [15:0] io_limit_upper,
   input wire brs_pkg::brs_io_req_t io_req,
   input wire logic io_fwd_valid,
   input wire logic io_fwd_hit,
   input wire logic [1:0] ctrl,
   input wire logic irq
);
   // ********************
   // Checks
   // ********************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   a_latency_zero:
      assert property ($past(bus_req.rd) && $past(bus_req.addr) == 8'h18 |-> rdata[31:24] == 8'h00)
      else $error("latency timer byte not zero");
   a_io_indicator:
      assert property ($past(bus_req.rd) && $past(bus_req.addr) == 8'h1c |->
         rdata[3:0] == 4'h1 && rdata[11:8] == 4'h1) else $error("io indicator not one");
   a_status_reserved:
      assert property ($past(bus_req.rd) && $past(bus_req.addr) == 8'h1c |->
         rdata[26:25] == 2'h0 && rdata[23:16] == 8'h00) else $error("fixed status bits set");
   a_fwd_pulse:
      assert property (io_fwd_valid == $past(io_req.valid)) else $error("decode answer slot");
   a_hit_upper:
      assert property (io_fwd_valid && ($past(io_req.addr[31:16]) < $past(io_base_upper) ||
         $past(io_req.addr[31:16]) > $past(io_limit_upper)) |-> !io_fwd_hit)
      else $error("hit outside upper half");
   a_hit_valid:
      assert property (io_fwd_hit |-> io_fwd_valid) else $error("hit without answer");
   a_irq_fall:
      assert property ($fell(irq) |-> $past(bus_req.rd) || $past(bus_req.wr))
      else $error("irq fell without access");
   a_irq_rise:
      assert property ($rose(irq) |-> $past(|events) || $past(bus_req.wr))
      else $error("irq rose without cause");
   a_ctrl_write:
      assert property ($changed(ctrl) |-> $past(bus_req.wr) && $past(bus_req.addr) == 8'h40)
      else $error("control changed without write");
   c_irq: cover property ($rose(irq));
   c_hit: cover property (io_fwd_hit);
   c_miss: cover property (io_fwd_valid && !io_fwd_hit);
endmodule // brs_properties

bind brs_top brs_properties u_props (.core_clk, .arst_n, .bus_req, .rdata, .events,
   .io_base_upper, .io_limit_upper, .io_req, .io_fwd_valid, .io_fwd_hit, .ctrl, .irq);

// File: verif/brs_top_tb_top.sv
// Self-checking bench for the bridge secondary-side bank
`timescale 1ns/1ns
module brs_top_tb_top;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   brs_pkg::brs_bus_req_t bus_req = '0;
   brs_pkg::brs_flags_t events = '0;
   brs_pkg::brs_io_req_t io_req = '0;
   logic [15:0] up_lo = 16'h0001;
   logic [15:0] up_hi = 16'h0002;
   logic [31:0] rdata;
   logic io_fwd_valid, io_fwd_hit, irq;
   logic [1:0] ctrl;
   int n_fail = 0;
   int n_compared = 0;
   // Both window edges and both upper halves sit in this table
   logic [31:0] io_addr [6] = '{32'h0001_1fff, 32'h0001_2000, 32'h0001_9000,
      32'h0002_5fff, 32'h0002_6000, 32'h0000_3000};
   logic [5:0] io_exp = 6'b001110;
   always #20 core_clk = ~core_clk;
   brs_top u_dut (.core_clk, .arst_n, .bus_req, .rdata, .events, .io_base_upper(up_lo),
      .io_limit_upper(up_hi), .io_req, .io_fwd_valid, .io_fwd_hit, .ctrl, .irq);
   // ********************
   // Tasks
   // ********************
   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(string nm, logic [7:0] a, logic [31:0] exp);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1 chk(nm, exp, rdata);
   endtask
   task automatic io(logic [31:0] a, logic exp);
      @(posedge core_clk);
      io_req <= '{valid: 1'b1, addr: a};
      @(posedge core_clk);
      io_req.valid <= 1'b0;
      #1 chk("io_fwd", {30'h0, 1'b1, exp}, {30'h0, io_fwd_valid, io_fwd_hit});
   endtask
   task automatic ev(brs_pkg::brs_flags_t v);
      @(posedge core_clk);
      events <= v;
      @(posedge core_clk);
      events <= '0;
   endtask
   // ********************
   // Tests
   // ********************
   initial begin
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      rd("bus_word", 8'h18, 32'h0);
      rd("io_status", 8'h1c, 32'h0000_0101);
      wr(8'h18, 32'hffff_ffff);
      rd("bus_word", 8'h18, 32'h00ff_0000);
      wr(8'h1c, 32'hffff_ffff);
      rd("io_status", 8'h1c, 32'h0000_f1f1);
      wr(8'h1c, 32'h0000_5020);
      for (int i = 0; i < 6; i++) io(io_addr[i], io_exp[i]);
      ev(6'h01);
      ev(6'h10);
      rd("io_status", 8'h1c, 32'h0000_5121);
      wr(8'h40, 32'h0000_0003);
      #1 chk("ctrl", 32'h3, {30'h0, ctrl});
      ev(6'h3f);
      rd("io_status", 8'h1c, 32'hf900_5121);
      wr(8'h1c, 32'h0100_5020);
      rd("io_status", 8'h1c, 32'hf800_5121);
      wr(8'h1c, 32'hff00_5020);
      rd("io_status", 8'h1c, 32'h3800_5121);
      rd("irq_status", 8'h48, 32'h0000_003f);
      chk("irq", 32'h0, {31'h0, irq});
      wr(8'h44, 32'h0000_0020);
      ev(6'h01);
      #1 chk("irq", 32'h0, {31'h0, irq});
      ev(6'h20);
      #1 chk("irq", 32'h1, {31'h0, irq});
      rd("irq_status", 8'h48, 32'h0000_0021);
      chk("irq", 32'h0, {31'h0, irq});
      rd("irq_status", 8'h48, 32'h0);
      rd("unmapped", 8'h30, 32'h0);
      print_verdict();
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      n_fail++;
      print_verdict();
   end
endmodule // brs_top_tb_top
